// [hdl/eds_write_pkg.sv]
// constants and types shared by both ends of the paged write path
`default_nettype none
package eds_write_pkg;
   localparam int EA_W        = 16;
   localparam int PAGE_REG_W  = 10;
   localparam int PAGE_USED_W = 9;
   localparam int OFFSET_W    = 15;
   localparam int EXT_ADDR_W  = 24;
   localparam int DATA_W      = 16;
   localparam int WINDOW_BIT  = 15;
   localparam logic [EA_W-1:0] WINDOW_BASE = 16'h8000;
   localparam logic [EA_W-1:0] WINDOW_TOP  = 16'hFFFF;
   localparam logic [EA_W-1:0] WORD_STEP   = 16'h0002;

   // access width selector
   typedef enum logic [1:0]
   {
      SZ_BYTE  = 2'b00,
      SZ_WORD  = 2'b01,
      SZ_DWORD = 2'b10
   } access_size_e;
endpackage
`default_nettype wire

// [hdl/eds_write_if.sv]
// interface joining the issuing core and the paged write logic
`timescale 1ns/1ps
`default_nettype none
interface eds_write_if;
   import eds_write_pkg::*;
   logic                  wr_valid;
   logic [EA_W-1:0]       effective_address;
   logic [DATA_W-1:0]     wr_data;
   logic [DATA_W-1:0]     wr_data_hi;
   access_size_e          wr_size;
   logic                  wr_rmw;
   logic                  wr_ready;
   logic                  page_load;
   logic                  page_sel_read;
   logic [PAGE_REG_W-1:0] page_value;
   modport core (output wr_valid, effective_address, wr_data, wr_data_hi, wr_size, wr_rmw,
                 page_load, page_sel_read, page_value, input wr_ready);
   modport dev  (input wr_valid, effective_address, wr_data, wr_data_hi, wr_size, wr_rmw,
                 page_load, page_sel_read, page_value, output wr_ready);
endinterface
`default_nettype wire

// [hdl/eds_write_dev.sv]
// paged extended-space write address generation
// Overview of operation
// - core loads page, then offset pointer
// - pointer bit 15 selects extended window
// - address is page[8:0] joined to ea[14:0]
// - no automatic page change on wrap
// - each extended write takes one cycle
// - no read-modify-write to the extended window inside repeat loops
// - read-modify-write uses the read page
// - byte, word, dword; dword is two writes
`timescale 1ns/1ps
`default_nettype none
module eds_write_dev
   import eds_write_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   eds_write_if.dev                   bus,
   output logic                       mem_we,
   output logic                       mem_ext,
   output logic [EXT_ADDR_W-1:0]      mem_addr,
   output logic [DATA_W-1:0]          mem_data,
   output logic                       mem_byte,
   output logic [PAGE_REG_W-1:0]      write_page_register,
   output logic [PAGE_REG_W-1:0]      read_page_register
);
   typedef struct packed
   {
      logic [PAGE_REG_W-1:0] wpage;
      logic [PAGE_REG_W-1:0] rpage;
      logic                  second;
      logic [EA_W-1:0]       second_ea;
      logic [DATA_W-1:0]     second_data;
      logic [PAGE_REG_W-1:0] second_page;
      logic                  we;
      logic                  ext;
      logic [EXT_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     data;
      logic                  byte_wr;
   } dev_s;

   dev_s st_r;
   dev_s st_nxt;

   // forms the outgoing address from pointer and page
   function automatic logic [EXT_ADDR_W-1:0] form_addr(input logic [EA_W-1:0] ea,
                                                       input logic [PAGE_REG_W-1:0] pg);
      if (ea[WINDOW_BIT])
         form_addr = {pg[PAGE_USED_W-1:0], ea[OFFSET_W-1:0]};
      else
         form_addr = {{(EXT_ADDR_W-EA_W){1'b0}}, ea};
   endfunction

   // ready only when no second dword half pending
   assign bus.wr_ready = ~st_r.second;

   // next-state logic
   always_comb
   begin
      logic [PAGE_REG_W-1:0] pg;
      logic [EA_W-1:0]       ea2;
      pg  = '0;
      ea2 = '0;
      st_nxt    = st_r;
      st_nxt.we = 1'b0;
      // page register loads by the core; never changed on wrap
      if (bus.page_load && !bus.page_sel_read)
         st_nxt.wpage = bus.page_value;
      if (bus.page_load && bus.page_sel_read)
         st_nxt.rpage = bus.page_value;
      if (st_r.second)
      begin
         // second half of a dword
         st_nxt.we      = 1'b1;
         st_nxt.ext     = st_r.second_ea[WINDOW_BIT];
         st_nxt.addr    = form_addr(st_r.second_ea, st_r.second_page);
         st_nxt.data    = st_r.second_data;
         st_nxt.byte_wr = 1'b0;
         st_nxt.second  = 1'b0;
      end
      else if (bus.wr_valid)
      begin
         pg = bus.wr_rmw ? st_r.rpage : st_r.wpage;
         st_nxt.we      = 1'b1;
         st_nxt.ext     = bus.effective_address[WINDOW_BIT];
         st_nxt.addr    = form_addr(bus.effective_address, pg);
         st_nxt.data    = bus.wr_data;
         st_nxt.byte_wr = (bus.wr_size == SZ_BYTE);
         if (bus.wr_size == SZ_DWORD)
         begin
            // next word address; pointer keeps window, page untouched
            ea2 = bus.effective_address + WORD_STEP;
            if (bus.effective_address[WINDOW_BIT] && !ea2[WINDOW_BIT])
               ea2 = ea2 | WINDOW_BASE;
            st_nxt.second      = 1'b1;
            st_nxt.second_ea   = ea2;
            st_nxt.second_data = bus.wr_data_hi;
            st_nxt.second_page = pg;
         end
      end
   end

   // state register
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign mem_we              = st_r.we;
   assign mem_ext             = st_r.ext;
   assign mem_addr            = st_r.addr;
   assign mem_data            = st_r.data;
   assign mem_byte            = st_r.byte_wr;
   assign write_page_register = st_r.wpage;
   assign read_page_register  = st_r.rpage;
endmodule
`default_nettype wire

// [hdl/eds_write_core.sv]
// issuing-core end: page setup and write issue
`timescale 1ns/1ps
`default_nettype none
module eds_write_core
   import eds_write_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   eds_write_if.core                  bus,
   input  wire logic                  req_page,
   input  wire logic                  req_page_read,
   input  wire logic [PAGE_REG_W-1:0] req_page_value,
   input  wire logic                  req_write,
   input  wire logic [EA_W-1:0]       req_offset,
   input  wire logic                  req_extended,
   input  wire logic [DATA_W-1:0]     req_data,
   input  wire logic [DATA_W-1:0]     req_data_hi,
   input  wire access_size_e          req_size,
   input  wire logic                  req_rmw,
   input  wire logic                  in_repeat,
   output logic                       req_ready,
   output logic                       req_rejected
);
   typedef struct packed
   {
      logic                  valid;
      logic [EA_W-1:0]       ea;
      logic [DATA_W-1:0]     data;
      logic [DATA_W-1:0]     data_hi;
      access_size_e          size;
      logic                  rmw;
      logic                  pload;
      logic                  psel;
      logic [PAGE_REG_W-1:0] pval;
      logic                  rej;
   } core_s;

   core_s st_r;
   core_s st_nxt;

   // held request waits for device ready
   assign req_ready = ~st_r.valid | bus.wr_ready;

   // next-state logic
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.pload = 1'b0;
      st_nxt.rej   = 1'b0;
      if (st_r.valid && bus.wr_ready)
         st_nxt.valid = 1'b0;
      // page load first, as software sets it before the pointer
      if (req_page)
      begin
         st_nxt.pload = 1'b1;
         st_nxt.psel  = req_page_read;
         st_nxt.pval  = req_page_value;
      end
      if (req_write && req_ready)
      begin
         if (req_rmw && in_repeat && req_extended)
            st_nxt.rej = 1'b1;
         else
         begin
            st_nxt.valid   = 1'b1;
            st_nxt.ea      = req_extended ? (req_offset | WINDOW_BASE) : req_offset;
            st_nxt.data    = req_data;
            st_nxt.data_hi = req_data_hi;
            st_nxt.size    = req_size;
            st_nxt.rmw     = req_rmw;
         end
      end
   end

   // state register
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign bus.wr_valid          = st_r.valid;
   assign bus.effective_address = st_r.ea;
   assign bus.wr_data           = st_r.data;
   assign bus.wr_data_hi        = st_r.data_hi;
   assign bus.wr_size           = st_r.size;
   assign bus.wr_rmw            = st_r.rmw;
   assign bus.page_load         = st_r.pload;
   assign bus.page_sel_read     = st_r.psel;
   assign bus.page_value        = st_r.pval;
   assign req_rejected          = st_r.rej;
endmodule
`default_nettype wire

// [tb/eds_write_asserts.sv]
// assertions on the paged write interface and page registers
`timescale 1ns/1ps
`default_nettype none
module eds_write_asserts
   import eds_write_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  sys_rst,
   input wire logic                  wr_valid,
   input wire logic [EA_W-1:0]       effective_address,
   input wire logic                  wr_ready,
   input wire logic                  wr_rmw,
   input wire access_size_e          wr_size,
   input wire logic                  page_load,
   input wire logic                  page_sel_read,
   input wire logic [PAGE_REG_W-1:0] page_value,
   input wire logic                  mem_we,
   input wire logic [EXT_ADDR_W-1:0] mem_addr,
   input wire logic [PAGE_REG_W-1:0] write_page_register,
   input wire logic [PAGE_REG_W-1:0] read_page_register
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // accepted request and the offset of the next word
   logic            take;
   logic [EA_W-1:0] ea_step;
   assign take = wr_valid && wr_ready;
   assign ea_step = effective_address + WORD_STEP;
   sequence win_take;
      take && effective_address[WINDOW_BIT];
   endsequence
   sequence dw_take;
      take && wr_size == SZ_DWORD;
   endsequence
   ext_addr_a: assert property (
      win_take ##0 !wr_rmw |=> mem_we && mem_addr ==
      {$past(write_page_register[8:0]), $past(effective_address[14:0])}) else $error("ext addr");
   plain_addr_a: assert property (
      take && !effective_address[WINDOW_BIT] |=> mem_we &&
      mem_addr == {8'h00, $past(effective_address)}) else $error("plain addr");
   rmw_page_a: assert property (
      win_take ##0 wr_rmw |=> mem_addr[23:15] == $past(read_page_register[8:0])) else $error("rmw");
   dword_pair_a: assert property (
      dw_take ##0 win_take |=> mem_we ##1 mem_we && mem_addr[14:0] == $past(ea_step[14:0], 2) &&
      mem_addr[23:15] == $past(mem_addr[23:15])) else $error("dword pair");
   dword_wait_a: assert property (
      dw_take |=> !wr_ready) else $error("dword wait");
   wpage_load_a: assert property (
      page_load && !page_sel_read |=> write_page_register == $past(page_value)) else $error("wpage");
   rpage_load_a: assert property (
      page_load && page_sel_read |=> read_page_register == $past(page_value)) else $error("rpage");
   page_hold_a: assert property (
      !page_load |=> $stable(write_page_register) && $stable(read_page_register)) else $error("hold");
endmodule
`default_nettype wire

// [tb/paged_data_space_write_tb.sv]
// bench driving the core end and watching the device end
`timescale 1ns/1ps
`default_nettype none
module paged_data_space_write_tb;
   import eds_write_pkg::*;
   logic                  mclk, sys_rst, req_page, req_page_read, req_write, req_extended;
   logic                  req_rmw, in_repeat, req_ready, req_rejected, mem_we, mem_ext, mem_byte;
   logic [PAGE_REG_W-1:0] req_page_value, write_page_register, read_page_register;
   logic [EA_W-1:0]       req_offset;
   logic [DATA_W-1:0]     req_data, req_data_hi, mem_data;
   logic [EXT_ADDR_W-1:0] mem_addr;
   access_size_e          req_size;
   int                    failures, checked;
   eds_write_if bus_if ();
   eds_write_core u_eds_write_core (.mclk, .sys_rst, .bus(bus_if.core), .req_page, .req_page_read,
      .req_page_value, .req_write, .req_offset, .req_extended, .req_data, .req_data_hi, .req_size,
      .req_rmw, .in_repeat, .req_ready, .req_rejected);
   eds_write_dev u_eds_write_dev (.mclk, .sys_rst, .bus(bus_if.dev), .mem_we, .mem_ext, .mem_addr,
      .mem_data, .mem_byte, .write_page_register, .read_page_register);
   eds_write_asserts u_eds_write_asserts (.mclk, .sys_rst, .wr_valid(bus_if.wr_valid),
      .effective_address(bus_if.effective_address), .wr_ready(bus_if.wr_ready),
      .wr_rmw(bus_if.wr_rmw), .wr_size(bus_if.wr_size), .page_load(bus_if.page_load),
      .page_sel_read(bus_if.page_sel_read), .page_value(bus_if.page_value), .mem_we, .mem_addr,
      .write_page_register, .read_page_register);
   // clock at 200 MHz
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      checked++;
      if (got !== want)
      begin
         failures++;
         $display("MISMATCH %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic load(input logic rd, input logic [PAGE_REG_W-1:0] v);
      @(posedge mclk);
      req_page <= 1'b1;
      req_page_read <= rd;
      req_page_value <= v;
      @(posedge mclk);
      req_page <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask
   // one write; refused ones must never reach memory
   task automatic wr(input logic [EA_W-1:0] off, input logic ext, input access_size_e sz,
      input logic rmw, input logic rep, input logic [EXT_ADDR_W-1:0] ea_x, input logic ok);
      int                n;
      logic [DATA_W-1:0] lo;
      lo = ~off;
      @(posedge mclk);
      req_write <= 1'b1;
      req_offset <= off;
      req_extended <= ext;
      req_size <= sz;
      req_rmw <= rmw;
      in_repeat <= rep;
      req_data <= lo;
      req_data_hi <= off;
      @(posedge mclk);
      req_write <= 1'b0;
      @(negedge mclk);
      chk(req_rejected, !ok);
      for (n = 0; n < 6 && mem_we !== 1'b1; n++)
         @(negedge mclk);
      chk(n < 6, ok);
      if (n < 6)
      begin
         chk(mem_addr, ea_x);
         chk(mem_data, lo);
         chk(mem_byte, sz == SZ_BYTE);
         chk(mem_ext, ext);
      end
      if (sz == SZ_DWORD)
      begin
         @(negedge mclk);
         chk(mem_we, 1'b1);
         chk(mem_addr, {ea_x[23:15], ea_x[14:0] + 15'h0002});
         chk(mem_data, off);
      end
      if (ok && n == 6)
         end_of_test();
   endtask
   task automatic t_pages();
      load(1'b0, 10'h002);
      chk(write_page_register, 10'h002);
      load(1'b1, 10'h3FF);
      chk(read_page_register, 10'h3FF);
      chk(write_page_register, 10'h002);
      $display("pages done");
   endtask
   task automatic t_writes();
      wr(16'h0800, 1'b1, SZ_WORD, 1'b0, 1'b0, 24'h01_0800, 1'b1);
      wr(16'h0801, 1'b1, SZ_BYTE, 1'b0, 1'b0, 24'h01_0801, 1'b1);
      wr(16'h1234, 1'b0, SZ_WORD, 1'b0, 1'b0, 24'h00_1234, 1'b1);
      wr(16'h7FFE, 1'b1, SZ_DWORD, 1'b0, 1'b0, 24'h01_7FFE, 1'b1);
      $display("writes done");
   endtask
   task automatic t_rmw();
      wr(16'h0010, 1'b1, SZ_WORD, 1'b1, 1'b0, 24'hFF_8010, 1'b1);
      wr(16'h0010, 1'b1, SZ_WORD, 1'b1, 1'b1, 24'h00_0000, 1'b0);
      $display("rmw done");
   endtask
   // dword followed at once by a word: core must hold the word
   task automatic t_stall();
      @(posedge mclk);
      req_write <= 1'b1;
      req_offset <= 16'h0100;
      req_extended <= 1'b1;
      req_size <= SZ_DWORD;
      req_rmw <= 1'b0;
      in_repeat <= 1'b0;
      req_data <= 16'h1111;
      req_data_hi <= 16'h2222;
      @(posedge mclk);
      req_offset <= 16'h0200;
      req_size <= SZ_WORD;
      req_data <= 16'h3333;
      @(posedge mclk);
      req_write <= 1'b0;
      @(negedge mclk);
      chk(req_ready, 1'b0);
      chk(mem_addr, 24'h01_0100);
      @(negedge mclk);
      chk(mem_addr, 24'h01_0102);
      chk(mem_data, 16'h2222);
      @(negedge mclk);
      chk(mem_we, 1'b1);
      chk(mem_addr, 24'h01_0200);
      chk(mem_data, 16'h3333);
      $display("stall done");
   endtask
   // mid-run reset clears page registers, then a write uses page zero
   task automatic t_reset();
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(negedge mclk);
      chk(write_page_register, 10'h000);
      chk(read_page_register, 10'h000);
      chk(mem_we, 1'b0);
      chk(req_ready, 1'b1);
      wr(16'h0004, 1'b1, SZ_WORD, 1'b0, 1'b0, 24'h00_0004, 1'b1);
      $display("reset done");
   endtask
   // reset, then the scenarios
   initial
   begin
      failures = 0;
      checked = 0;
      sys_rst = 1'b1;
      {req_page, req_page_read, req_write, req_extended, req_rmw, in_repeat} = '0;
      {req_page_value, req_offset, req_data, req_data_hi} = '0;
      req_size = SZ_WORD;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      t_pages();
      t_writes();
      t_rmw();
      t_stall();
      t_reset();
      end_of_test();
   end
endmodule
`default_nettype wire
